/* File: logic/pnp_device.sv */
// Device end of the parallel programming port: loads, page buffers, writes.
`timescale 1ns/1ps
module pnp_device
   import pnp_pkg::*;
#(
   parameter int FLASH_AW = 12,
   parameter int PAGE_BITS = 6,
   parameter int EE_AW = 9,
   parameter int EE_PAGE_BITS = 3
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic ce,
   pnp_if.device link,
   output logic [7:0] fuseLow_q,
   output logic [7:0] fuseHigh_q,
   output logic [7:0] fuseExt_q
);
   localparam int PAGE_WORDS = 1 << PAGE_BITS;
   localparam int EE_PAGE = 1 << EE_PAGE_BITS;

   typedef enum logic [2:0] {
      WOP_FLASH = 3'b001,
      WOP_EE = 3'b010,
      WOP_FUSE = 3'b100
   } pnp_wop_t;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchroniser and strobe edge detection.

   logic [15:0] pinRaw;
   logic [15:0] sync1_q;
   logic [15:0] sync2_q;
   logic [2:0] strobePrev_q;
   logic [1:0] action;
   logic bs1;
   logic bs2;
   logic loadStb;
   logic latchStb;
   logic wrStb_n;
   logic oeStb_n;
   logic [7:0] busIn;
   logic loadRise;
   logic latchRise;
   logic wrFall;

   assign pinRaw = {link.actionSelectHi, link.actionSelectLo,
                    link.byteSelectOne, link.byteSelectTwo,
                    link.loadStrobeClockIn, link.pageLatchStrobe,
                    link.writeStrobe_n, link.outputEnable_n, link.dataBus};
   assign action = sync2_q[15:14];
   assign bs1 = sync2_q[13];
   assign bs2 = sync2_q[12];
   assign loadStb = sync2_q[11];
   assign latchStb = sync2_q[10];
   assign wrStb_n = sync2_q[9];
   assign oeStb_n = sync2_q[8];
   assign busIn = sync2_q[7:0];

   // Every pin passes two flops together, so controls and strobes stay
   // aligned and the setup and hold of the pins carry over unchanged.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= 16'h03FF;
         sync2_q <= 16'h03FF;
         strobePrev_q <= 3'h1;
      end else if (ce) begin
         sync1_q <= pinRaw;
         sync2_q <= sync1_q;
         strobePrev_q <= {loadStb, latchStb, wrStb_n};
      end
   end

   assign loadRise = loadStb && !strobePrev_q[2];
   assign latchRise = latchStb && !strobePrev_q[1];
   assign wrFall = !wrStb_n && strobePrev_q[0];

   ////////////////////////////////////////////////////////////////////////
   // Command, address and data byte registers.

   logic [7:0] cmd_q;
   logic [7:0] addrLo_q;
   logic [7:0] addrHi_q;
   logic [7:0] dataLo_q;
   logic [7:0] dataHi_q;
   logic nopLoad;
   logic busy;

   assign nopLoad = loadRise && action == ACT_CMD && !bs1
                    && busIn == CMD_NOP;

   // Values stay until overwritten, so one command serves many addresses.
   // Loads during a busy period are refused to keep the write intact.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cmd_q <= CMD_NOP;
         addrLo_q <= 8'h00;
         addrHi_q <= 8'h00;
         dataLo_q <= 8'h00;
         dataHi_q <= 8'h00;
      end else if (ce && loadRise && !busy) begin
         unique case (action)
            ACT_CMD: begin
               if (!bs1) begin
                  cmd_q <= busIn;
               end
            end
            ACT_ADDR: begin
               if (bs1) begin
                  addrHi_q <= busIn;
               end else begin
                  addrLo_q <= busIn;
               end
            end
            ACT_DATA: begin
               if (bs1) begin
                  dataHi_q <= busIn;
               end else begin
                  dataLo_q <= busIn;
               end
            end
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Page buffers.

   logic [15:0] pageBuf [PAGE_WORDS];
   logic [7:0] eeBuf [EE_PAGE];
   logic armed_q;
   logic [PAGE_BITS-1:0] wordIdx;
   logic [EE_PAGE_BITS-1:0] eeIdx;

   assign wordIdx = addrLo_q[PAGE_BITS-1:0];
   assign eeIdx = addrLo_q[EE_PAGE_BITS-1:0];

   // A flash latch needs bs1 high and the flash write command; an EEPROM latch needs only its write command.
   always_ff @(posedge clock) begin
      if (ce && latchRise && !busy) begin
         if (cmd_q == CMD_WR_FLASH && bs1) begin
            pageBuf[wordIdx] <= {dataHi_q, dataLo_q};
         end
         if (cmd_q == CMD_WR_EE) begin
            eeBuf[eeIdx] <= dataLo_q;
         end
      end
   end

   // Armed marks buffered data; the no-operation command drops it.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         armed_q <= 1'b0;
      end else if (ce) begin
         if (nopLoad && !busy) begin
            armed_q <= 1'b0;
         end else if (latchRise && !busy && (cmd_q == CMD_WR_EE
                      || (cmd_q == CMD_WR_FLASH && bs1))) begin
            armed_q <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Self-timed write sequencer.

   logic [7:0] busyCnt_q;
   pnp_wop_t wop_q;
   logic [1:0] fuseSel_q;
   logic commit;

   assign busy = busyCnt_q != 8'h00;
   assign commit = ce && busyCnt_q == 8'h01;

   // A write pulse is ignored while a previous write is still running.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         busyCnt_q <= 8'h00;
         wop_q <= WOP_FLASH;
         fuseSel_q <= 2'h0;
         link.readyBusy_n <= 1'b1;
      end else if (ce) begin
         if (wrFall && !busy && ((armed_q && !bs1 && (cmd_q == CMD_WR_FLASH
             || cmd_q == CMD_WR_EE)) || cmd_q == CMD_WR_FUSE)) begin
            busyCnt_q <= 8'(WLRH_CYC);
            link.readyBusy_n <= 1'b0;
            fuseSel_q <= {bs2, bs1};
            if (cmd_q == CMD_WR_FUSE) begin
               wop_q <= WOP_FUSE;
            end else if (cmd_q == CMD_WR_EE) begin
               wop_q <= WOP_EE;
            end else begin
               wop_q <= WOP_FLASH;
            end
         end else if (busy) begin
            busyCnt_q <= busyCnt_q - 8'h01;
            link.readyBusy_n <= busyCnt_q == 8'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Nonvolatile arrays, updated when the timed write finishes.

   logic [15:0] flashMem [1 << FLASH_AW];
   logic [7:0] eeMem [1 << EE_AW];
   logic [15:0] fullAddr;
   logic [FLASH_AW-PAGE_BITS-1:0] pageSel;
   logic [EE_AW-EE_PAGE_BITS-1:0] eePageSel;

   assign fullAddr = {addrHi_q, addrLo_q};
   assign pageSel = fullAddr[FLASH_AW-1:PAGE_BITS];
   assign eePageSel = fullAddr[EE_AW-1:EE_PAGE_BITS];

   // The whole page is copied at once; unlatched words take whatever the page buffer still holds.
   always_ff @(posedge clock) begin
      if (commit && wop_q == WOP_FLASH) begin
         for (int i = 0; i < PAGE_WORDS; i++) begin
            flashMem[{pageSel, PAGE_BITS'(i)}] <= pageBuf[i];
         end
      end
      if (commit && wop_q == WOP_EE) begin
         for (int i = 0; i < EE_PAGE; i++) begin
            eeMem[{eePageSel, EE_PAGE_BITS'(i)}] <= eeBuf[i];
         end
      end
   end

   // Zero bits program a fuse, one bits erase it; bs2 outranks bs1.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         fuseLow_q <= FUSE_RESET;
         fuseHigh_q <= FUSE_RESET;
         fuseExt_q <= FUSE_RESET;
      end else if (commit && wop_q == WOP_FUSE) begin
         if (fuseSel_q[1]) begin
            fuseExt_q <= dataLo_q;
         end else if (fuseSel_q[0]) begin
            fuseHigh_q <= dataLo_q;
         end else begin
            fuseLow_q <= dataLo_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path; the data pins are driven only under output enable.

   logic [15:0] rdWord;
   logic [7:0] rdByte;

   assign rdWord = flashMem[fullAddr[FLASH_AW-1:0]];
   assign rdByte = eeMem[fullAddr[EE_AW-1:0]];

   // Read data follows bs1 one cycle after the synchronised pins change.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         link.devDataOut <= 8'h00;
         link.devDataOe <= 1'b0;
      end else if (ce) begin
         link.devDataOe <= 1'b0;
         if (!oeStb_n && cmd_q == CMD_RD_FLASH) begin
            link.devDataOe <= 1'b1;
            link.devDataOut <= bs1 ? rdWord[15:8] : rdWord[7:0];
         end else if (!oeStb_n && cmd_q == CMD_RD_EE && !bs1) begin
            link.devDataOe <= 1'b1;
            link.devDataOut <= rdByte;
         end
      end
   end
endmodule : pnp_device

/* File: logic/pnp_pkg.sv */
// Shared constants for the parallel programming port and its programmer.
package pnp_pkg;
   // Action-select codes on {action_select_hi, action_select_lo}.
   localparam logic [1:0] ACT_ADDR = 2'h0;
   localparam logic [1:0] ACT_DATA = 2'h1;
   localparam logic [1:0] ACT_CMD = 2'h2;
   // Command codes.
   localparam logic [7:0] CMD_NOP = 8'h00;
   localparam logic [7:0] CMD_WR_FLASH = 8'h10;
   localparam logic [7:0] CMD_WR_EE = 8'h11;
   localparam logic [7:0] CMD_RD_FLASH = 8'h02;
   localparam logic [7:0] CMD_RD_EE = 8'h03;
   localparam logic [7:0] CMD_WR_FUSE = 8'h40;
   // Reset values.
   localparam logic [7:0] FUSE_RESET = 8'hFF;
   localparam logic [7:0] MEM_RESET = 8'hFF;
   // Timing, figures in ns, counts in cycles of the 100 ns clock.
   localparam int CLK_PERIOD_NS = 100;
   localparam int T_WLRH_MIN_NS = 3700;
   localparam int T_WLRL_MAX_NS = 1000;
   localparam int T_PULSE_MIN_NS = 150;
   localparam int T_SETUP_MIN_NS = 67;
   localparam int T_OLDV_MAX_NS = 250;
   localparam int WLRH_CYC = (T_WLRH_MIN_NS + CLK_PERIOD_NS - 1)
                             / CLK_PERIOD_NS;
   localparam int WLRL_CYC = T_WLRL_MAX_NS / CLK_PERIOD_NS;
   localparam int PULSE_CYC = (T_PULSE_MIN_NS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
   localparam int SETUP_CYC = (T_SETUP_MIN_NS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
   // Pin synchroniser plus output register inside the device.
   localparam int DEV_LAT_CYC = 3;
   localparam int READ_CYC = (T_OLDV_MAX_NS + CLK_PERIOD_NS - 1)
                             / CLK_PERIOD_NS + DEV_LAT_CYC;
   // Programmer request kinds.
   typedef enum logic [2:0] {
      OP_CMD = 3'h0,
      OP_ADDR_LO = 3'h1,
      OP_ADDR_HI = 3'h2,
      OP_DATA_LO = 3'h3,
      OP_DATA_HI = 3'h4,
      OP_LATCH = 3'h5,
      OP_WRITE = 3'h6,
      OP_READ = 3'h7
   } pnp_op_t;
endpackage : pnp_pkg

/* File: logic/pnp_if.sv */
// Pin bundle between the programmer and the programming port.
`timescale 1ns/1ps
interface pnp_if;
   logic actionSelectHi;
   logic actionSelectLo;
   logic byteSelectOne;
   logic byteSelectTwo;
   logic loadStrobeClockIn;
   logic pageLatchStrobe;
   logic writeStrobe_n;
   logic outputEnable_n;
   logic readyBusy_n;
   logic [7:0] hostDataOut;
   logic hostDataOe;
   logic [7:0] devDataOut;
   logic devDataOe;
   logic [7:0] dataBus;

   // Resolved bus level; an undriven bus floats high here.
   assign dataBus = hostDataOe ? hostDataOut :
                    (devDataOe ? devDataOut : 8'hFF);

   modport device (
      input actionSelectHi, actionSelectLo, byteSelectOne, byteSelectTwo,
      input loadStrobeClockIn, pageLatchStrobe, writeStrobe_n,
      input outputEnable_n, dataBus,
      output readyBusy_n, devDataOut, devDataOe
   );
   modport programmer (
      output actionSelectHi, actionSelectLo, byteSelectOne, byteSelectTwo,
      output loadStrobeClockIn, pageLatchStrobe, writeStrobe_n,
      output outputEnable_n, hostDataOut, hostDataOe,
      input readyBusy_n, dataBus
   );
endinterface : pnp_if

/* File: logic/pnp_programmer.sv */
// Programmer end: turns user requests into timed pin sequences.
`timescale 1ns/1ps
module pnp_programmer
   import pnp_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic ce,
   pnp_if.programmer link,
   input wire logic reqValid,
   input wire pnp_op_t reqOp,
   input wire logic [7:0] reqData,
   input wire logic reqBs1,
   input wire logic reqBs2,
   output logic reqReady_q,
   output logic rdValid_q,
   output logic [7:0] rdData_q
);
   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_SETUP = 6'b000010,
      ST_PULSE = 6'b000100,
      ST_HOLD = 6'b001000,
      ST_WAIT = 6'b010000,
      ST_READ = 6'b100000
   } pnp_hst_t;

   pnp_hst_t state_q;
   pnp_op_t op_q;
   logic [7:0] cnt_q;
   logic [1:0] rbSync_q;

   ////////////////////////////////////////////////////////////////////////
   // Ready/busy is a pin from the device, so it is synchronised first.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rbSync_q <= 2'h3;
      end else if (ce) begin
         rbSync_q <= {rbSync_q[0], link.readyBusy_n};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer: set controls, pulse the strobe, then hold or wait; a read samples instead, then holds.
   // Controls stay put from setup to hold so the device sees them stable.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         op_q <= OP_CMD;
         cnt_q <= 8'h00;
         reqReady_q <= 1'b1;
         rdValid_q <= 1'b0;
         rdData_q <= 8'h00;
         link.actionSelectHi <= 1'b0;
         link.actionSelectLo <= 1'b0;
         link.byteSelectOne <= 1'b0;
         link.byteSelectTwo <= 1'b0;
         link.loadStrobeClockIn <= 1'b0;
         link.pageLatchStrobe <= 1'b0;
         link.writeStrobe_n <= 1'b1;
         link.outputEnable_n <= 1'b1;
         link.hostDataOut <= 8'h00;
         link.hostDataOe <= 1'b0;
      end else if (ce) begin
         rdValid_q <= 1'b0;
         unique case (state_q)
            ST_IDLE: begin
               if (reqValid) begin
                  op_q <= reqOp;
                  reqReady_q <= 1'b0;
                  cnt_q <= 8'(SETUP_CYC);
                  state_q <= ST_SETUP;
                  link.actionSelectHi <= reqOp == OP_CMD;
                  link.actionSelectLo <= reqOp == OP_DATA_LO
                                         || reqOp == OP_DATA_HI;
                  link.byteSelectOne <= reqOp == OP_ADDR_HI
                     || reqOp == OP_DATA_HI || reqOp == OP_LATCH
                     || ((reqOp == OP_WRITE || reqOp == OP_READ)
                         && reqBs1);
                  link.byteSelectTwo <= reqOp == OP_WRITE && reqBs2;
                  link.hostDataOut <= reqData;
                  link.hostDataOe <= reqOp != OP_READ;
                  link.outputEnable_n <= reqOp != OP_READ;
               end
            end
            ST_SETUP: begin
               if (cnt_q <= 8'h01) begin
                  cnt_q <= 8'(PULSE_CYC);
                  state_q <= op_q == OP_READ ? ST_READ : ST_PULSE;
                  if (op_q == OP_READ) begin
                     cnt_q <= 8'(READ_CYC);
                  end
                  link.loadStrobeClockIn <= op_q != OP_LATCH
                                            && op_q != OP_WRITE
                                            && op_q != OP_READ;
                  link.pageLatchStrobe <= op_q == OP_LATCH;
                  link.writeStrobe_n <= op_q != OP_WRITE;
               end else begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            ST_PULSE: begin
               if (cnt_q <= 8'h01) begin
                  link.loadStrobeClockIn <= 1'b0;
                  link.pageLatchStrobe <= 1'b0;
                  link.writeStrobe_n <= 1'b1;
                  cnt_q <= op_q == OP_WRITE ? 8'(WLRL_CYC)
                                            : 8'(SETUP_CYC + DEV_LAT_CYC);
                  state_q <= op_q == OP_WRITE ? ST_WAIT : ST_HOLD;
               end else begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            ST_HOLD, ST_WAIT: begin
               if (cnt_q > 8'h00) begin
                  cnt_q <= cnt_q - 8'h01;
               end else if (state_q == ST_HOLD || rbSync_q[1]) begin
                  // Back to idle drops any raised byte select.
                  state_q <= ST_IDLE;
                  reqReady_q <= 1'b1;
                  link.byteSelectOne <= 1'b0;
                  link.byteSelectTwo <= 1'b0;
                  link.hostDataOe <= 1'b0;
               end
            end
            ST_READ: begin
               if (cnt_q <= 8'h01) begin
                  rdValid_q <= 1'b1;
                  rdData_q <= link.dataBus;
                  link.outputEnable_n <= 1'b1;
                  link.byteSelectOne <= 1'b0;
                  cnt_q <= 8'(DEV_LAT_CYC);
                  state_q <= ST_HOLD;
               end else begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
         endcase
      end
   end
endmodule : pnp_programmer

/* File: testbench/pnp_chk.sv */
// Pin-level checks between the programmer and the programming port.
`timescale 1ns/1ps
module pnp_chk
   import pnp_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic loadStrobeClockIn,
   input wire logic pageLatchStrobe,
   input wire logic writeStrobe_n,
   input wire logic outputEnable_n,
   input wire logic readyBusy_n,
   input wire logic hostDataOe,
   input wire logic devDataOe
);
   int busyCnt_q;
   ////////////////////////////////////////////////////////////////////////
   // Busy cycles are counted so the self-timed length is checked exactly.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         busyCnt_q <= 0;
      end else if (readyBusy_n) begin
         busyCnt_q <= 0;
      end else begin
         busyCnt_q <= busyCnt_q + 1;
      end
   end
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////
   property p_noFight;
      !(hostDataOe && devDataOe);
   endproperty
   a_noFight: assert property (p_noFight)
      else $error("data bus driven by both ends");
   // The device answers a read a few cycles after the enable pin.
   property p_devOe;
      devDataOe |-> (!$past(outputEnable_n, 2) || !$past(outputEnable_n, 3)
         || !$past(outputEnable_n, 4));
   endproperty
   a_devOe: assert property (p_devOe)
      else $error("device drove bus without output enable");
   property p_hostOff;
      !outputEnable_n |-> !hostDataOe;
   endproperty
   a_hostOff: assert property (p_hostOff)
      else $error("programmer drove bus during a read");
   property p_busyCause;
      $fell(readyBusy_n) |-> (!$past(writeStrobe_n, 2)
         || !$past(writeStrobe_n, 3) || !$past(writeStrobe_n, 4));
   endproperty
   a_busyCause: assert property (p_busyCause)
      else $error("busy started without a write pulse");
   property p_busyLen;
      $rose(readyBusy_n) |-> busyCnt_q == WLRH_CYC;
   endproperty
   a_busyLen: assert property (p_busyLen)
      else $error("busy period has the wrong length");
   property p_busyQuiet;
      !readyBusy_n |-> !loadStrobeClockIn && !pageLatchStrobe;
   endproperty
   a_busyQuiet: assert property (p_busyQuiet)
      else $error("strobe given while busy");
   property p_loadData;
      loadStrobeClockIn |-> hostDataOe;
   endproperty
   a_loadData: assert property (p_loadData)
      else $error("load strobe without data driven");
   property p_loadWidth;
      $rose(loadStrobeClockIn) |=> loadStrobeClockIn;
   endproperty
   a_loadWidth: assert property (p_loadWidth)
      else $error("load strobe too short");
   property p_latchWidth;
      $rose(pageLatchStrobe) |=> pageLatchStrobe;
   endproperty
   a_latchWidth: assert property (p_latchWidth)
      else $error("page latch strobe too short");
   // The programmer holds the write strobe low for exactly two cycles.
   property p_wrWidth;
      $fell(writeStrobe_n) |=> !writeStrobe_n ##1 writeStrobe_n;
   endproperty
   a_wrWidth: assert property (p_wrWidth)
      else $error("write pulse has the wrong width");
endmodule : pnp_chk

/* File: testbench/tb_top.sv */
// Bench joining the programmer and programming port back to back.
`timescale 1ns/1ps
module tb_top
   import pnp_pkg::*;
;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic reqValid = 1'b0;
   pnp_op_t reqOp = OP_CMD;
   logic [7:0] reqData = 8'h00;
   logic reqBs1 = 1'b0;
   logic reqBs2 = 1'b0;
   logic reqReady_q;
   logic rdValid_q;
   logic [7:0] rdData_q;
   logic [7:0] fuseLow_q;
   logic [7:0] fuseHigh_q;
   logic [7:0] fuseExt_q;
   logic [7:0] got;
   logic sawBusy = 1'b0;
   int failures = 0;
   int checked = 0;
   int cycles = 0;
   pnp_if link();
   ////////////////////////////////////////////////////////////////////////
   // Clock and instances; only the clock enable is tied.
   always #50 clock = ~clock;
   pnp_device i_pnp_device (.clock(clock), .rst_n(rst_n), .ce(ce),
      .link(link.device), .fuseLow_q(fuseLow_q), .fuseHigh_q(fuseHigh_q),
      .fuseExt_q(fuseExt_q));
   pnp_programmer i_pnp_programmer (.clock(clock), .rst_n(rst_n), .ce(ce),
      .link(link.programmer), .reqValid(reqValid), .reqOp(reqOp),
      .reqData(reqData), .reqBs1(reqBs1), .reqBs2(reqBs2),
      .reqReady_q(reqReady_q), .rdValid_q(rdValid_q), .rdData_q(rdData_q));
   pnp_chk i_pnp_chk (.clock(clock), .rst_n(rst_n),
      .loadStrobeClockIn(link.loadStrobeClockIn),
      .pageLatchStrobe(link.pageLatchStrobe),
      .writeStrobe_n(link.writeStrobe_n),
      .outputEnable_n(link.outputEnable_n), .readyBusy_n(link.readyBusy_n),
      .hostDataOe(link.hostDataOe), .devDataOe(link.devDataOe));
   ////////////////////////////////////////////////////////////////////////
   // Busy is sampled every cycle since a refused write never shows it.
   always @(posedge clock) begin
      if (link.readyBusy_n === 1'b0) begin
         sawBusy <= 1'b1;
      end
   end
   // A hang is cut short well above the expected run of under a thousand cycles.
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, cycles, 0);
         final_report();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : final_report
   task automatic check(input logic [7:0] gotV, input logic [7:0] expV);
      checked++;
      if (gotV !== expV) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, gotV, expV);
      end
   endtask : check
   // One request; read data is caught from the one-cycle valid pulse.
   task automatic op(input pnp_op_t o, input logic [7:0] d,
                     input logic b1 = 1'b0, input logic b2 = 1'b0);
      int n;
      n = 0;
      got = 8'hXX;
      while (!reqReady_q && n < 2000) begin
         @(negedge clock);
         n++;
      end
      reqOp = o;
      reqData = d;
      reqBs1 = b1;
      reqBs2 = b2;
      reqValid = 1'b1;
      @(negedge clock);
      reqValid = 1'b0;
      repeat (2) @(negedge clock);
      n = 0;
      while (reqReady_q !== 1'b1 && n < 2000) begin
         if (rdValid_q === 1'b1) begin
            got = rdData_q;
         end
         @(negedge clock);
         n++;
      end
      // A request that never completes counts as a mismatch.
      if (n >= 2000) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, reqReady_q, 1'b1);
      end
   endtask : op
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(negedge clock);
      rst_n = 1'b1;
      @(negedge clock);
      check(fuseLow_q, FUSE_RESET);
      check(fuseExt_q & fuseHigh_q, FUSE_RESET);
      // Four words in page 1; bit 6 of the low address picks the page.
      op(OP_CMD, CMD_WR_FLASH);
      for (int w = 0; w < 4; w++) begin
         op(OP_ADDR_LO, 8'h40 + w[7:0]);
         op(OP_DATA_LO, 8'h10 + w[7:0]);
         op(OP_DATA_HI, 8'hC0 + w[7:0]);
         op(OP_LATCH, 8'h00, 1'b1);
      end
      op(OP_ADDR_HI, 8'h00);
      sawBusy = 1'b0;
      op(OP_WRITE, 8'h00);
      check({7'h00, sawBusy}, 8'h01);
      // After the no-op nothing is armed, so a write must be refused.
      op(OP_CMD, CMD_NOP);
      op(OP_CMD, CMD_WR_FLASH);
      sawBusy = 1'b0;
      op(OP_WRITE, 8'h00);
      check({7'h00, sawBusy}, 8'h00);
      // The read command is loaded once for all the words.
      op(OP_CMD, CMD_RD_FLASH);
      op(OP_ADDR_HI, 8'h00);
      for (int w = 0; w < 4; w++) begin
         op(OP_ADDR_LO, 8'h40 + w[7:0]);
         op(OP_READ, 8'h00, 1'b0);
         check(got, 8'h10 + w[7:0]);
         op(OP_READ, 8'h00, 1'b1);
         check(got, 8'hC0 + w[7:0]);
      end
      op(OP_CMD, CMD_WR_EE);
      op(OP_ADDR_HI, 8'h01);
      for (int i = 0; i < 2; i++) begin
         op(OP_ADDR_LO, 8'h08 + i[7:0]);
         op(OP_DATA_LO, 8'hA0 + i[7:0]);
         op(OP_LATCH, 8'h00);
      end
      sawBusy = 1'b0;
      op(OP_WRITE, 8'h00);
      check({7'h00, sawBusy}, 8'h01);
      op(OP_CMD, CMD_RD_EE);
      op(OP_ADDR_HI, 8'h01);
      for (int i = 0; i < 2; i++) begin
         op(OP_ADDR_LO, 8'h08 + i[7:0]);
         op(OP_READ, 8'h00, 1'b0);
         check(got, 8'hA0 + i[7:0]);
      end
      // With byte select one high the device stays off the bus.
      op(OP_READ, 8'h00, 1'b1);
      check(got, 8'hFF);
      // Low, high and extended fuse bytes in turn under one command.
      op(OP_CMD, CMD_WR_FUSE);
      for (int s = 0; s < 3; s++) begin
         op(OP_DATA_LO, 8'h5A ^ s[7:0]);
         op(OP_WRITE, 8'h00, s == 1, s == 2);
         check({6'h00, link.byteSelectTwo, link.byteSelectOne}, 8'h00);
      end
      check(fuseLow_q, 8'h5A);
      check(fuseHigh_q, 8'h5B);
      check(fuseExt_q, 8'h58);
      final_report();
   end
endmodule : tb_top
